// file: hdl/vec_mode_timing.sv
// output mode and timing mode control registers with the sync timing counters
module vec_mode_timing #(
  parameter logic [6:0] DEV_ADDR = 7'(vec_pkg::TWI_DEV_ADDR),
  parameter int NTSC_LINE = vec_pkg::NTSC_LINE_CYC,
  parameter int PAL_LINE = vec_pkg::PAL_LINE_CYC,
  parameter int NTSC_FRAME = vec_pkg::NTSC_LINES,
  parameter int PAL_FRAME = vec_pkg::PAL_LINES,
  parameter int HS_WIDTH = vec_pkg::HS_WIDTH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic pal_select,
  input wire logic hsync_in_n,
  input wire logic vsync_in_n,
  input wire logic blank_in_n,
  output logic hsync_out_n,
  output logic vsync_out_n,
  output logic output_format_select,
  output logic component_standard_select,
  output logic sync_on_colour_enable,
  output logic long_vert_sync_mode,
  output logic setup_pedestal_enable,
  output logic blanking_region_filter_enable,
  output logic low_power_sleep_enable,
  output logic master_slave_select,
  output logic [1:0] timing_mode_field,
  output logic blank_input_enable,
  output logic [1:0] luma_delay_field,
  output logic [7:0] luma_delay_cycles,
  output logic pixel_port_format,
  output logic colour_dac_ypbpr,
  output logic colour_dac_sync,
  output logic blank_force,
  output logic [10:0] h_count,
  output logic [9:0] v_count
);
  typedef struct packed {
    logic [7:0] omr;
    logic [7:0] tmr;
    logic [2:0] in_m;
    logic [2:0] in_s;
    logic [2:0] in_p;
    logic [10:0] h;
    logic [9:0] v;
    logic hs_n, vs_n, ypbpr, rgb_sync, ped, blank;
    logic [7:0] luma;
  } vec_state_t;
  vec_state_t s_r, s_nxt;

  logic reg_wr;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic master, hold, line_end;
  logic [10:0] line_len, half_len;
  logic [9:0] frame_len;
  logic [11:0] half_idx, vs_len;
  logic hs_fall, vs_fall;

  vec_twi_slave #(.DEV_ADDR(DEV_ADDR)) u_port (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  always_comb begin
    case (reg_addr)
      vec_pkg::OMR_ADDR: reg_rdata = s_r.omr;
      vec_pkg::TMR_ADDR: reg_rdata = s_r.tmr;
      default: reg_rdata = 8'h00;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    master = s_r.tmr[vec_pkg::TM_MS];
    // timing reset high holds counters; sleep freezes them
    hold = s_r.tmr[vec_pkg::TM_RST] | s_r.omr[vec_pkg::OM_SLEEP];
    line_len = pal_select ? 11'(PAL_LINE) : 11'(NTSC_LINE);
    half_len = {1'b0, line_len[10:1]};
    frame_len = pal_select ? 10'(PAL_FRAME) : 10'(NTSC_FRAME);
    line_end = (s_r.h == line_len - 11'h001);
    hs_fall = s_r.in_p[0] & ~s_r.in_s[0];
    vs_fall = s_r.in_p[1] & ~s_r.in_s[1];
    half_idx = {1'b0, s_r.v, 1'b0} + {11'h000, (s_r.h >= half_len)};
    // long vertical sync width in half lines
    if (s_r.omr[vec_pkg::OM_LVS]) begin
      vs_len = pal_select ? 12'(vec_pkg::VS_LONG_PAL_HALF) : 12'(vec_pkg::VS_LONG_NTSC_HALF);
    end else begin
      vs_len = 12'(vec_pkg::VS_STD_HALF);
    end
    // register writes accepted in sleep too
    if (reg_wr && reg_addr == vec_pkg::OMR_ADDR) s_nxt.omr = reg_wdata;
    if (reg_wr && reg_addr == vec_pkg::TMR_ADDR) s_nxt.tmr = reg_wdata;
    s_nxt.in_m = {blank_in_n, vsync_in_n, hsync_in_n};
    s_nxt.in_s = s_r.in_m;
    s_nxt.in_p = s_r.in_s;
    // counters restart from zero when the reset bit falls
    if (s_r.tmr[vec_pkg::TM_RST]) begin
      s_nxt.h = 11'h000;
      s_nxt.v = 10'h000;
    end else if (!hold) begin
      s_nxt.h = line_end ? 11'h000 : s_r.h + 11'h001;
      if (line_end) s_nxt.v = (s_r.v == frame_len - 10'h001) ? 10'h000 : s_r.v + 10'h001;
      // slave vsync of any length is tolerated, only its edge is used
      if (!master && hs_fall) s_nxt.h = 11'h000;
      if (!master && vs_fall) s_nxt.v = 10'h000;
    end
    // slave mode leaves the sync outputs idle high
    s_nxt.hs_n = ~(master & ~hold & (s_r.h < 11'(HS_WIDTH)));
    // vertical sync low for the programmed half lines
    s_nxt.vs_n = ~(master & ~hold & (half_idx < vs_len));
    // component standard only meaningful with component output
    s_nxt.ypbpr = s_r.omr[vec_pkg::OM_FMT] & s_r.omr[vec_pkg::OM_COMP];
    s_nxt.rgb_sync = s_r.omr[vec_pkg::OM_FMT] & s_r.omr[vec_pkg::OM_SYNC];
    s_nxt.ped = s_r.omr[vec_pkg::OM_PED] & ~pal_select;
    // external blank only honoured in slave mode
    s_nxt.blank = ~master & s_r.tmr[vec_pkg::TM_BLANK] & ~s_r.in_s[2];
    // each step of the field is one luma delay step
    s_nxt.luma = 8'(s_r.tmr[vec_pkg::TM_LUMA +: 2] * vec_pkg::LUMA_STEP_CYC);
  end

  // reset clears the sleep bit along with the rest of both control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{omr: vec_pkg::OMR_RST, tmr: vec_pkg::TMR_RST, in_m: 3'h7, in_s: 3'h7,
               in_p: 3'h7, h: 11'h000, v: 10'h000, hs_n: 1'b1, vs_n: 1'b1,
               ypbpr: 1'b0, rgb_sync: 1'b0, ped: 1'b0, blank: 1'b0, luma: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  // format select straight from the register
  assign output_format_select = s_r.omr[vec_pkg::OM_FMT];
  assign component_standard_select = s_r.omr[vec_pkg::OM_COMP];
  assign sync_on_colour_enable = s_r.omr[vec_pkg::OM_SYNC];
  assign long_vert_sync_mode = s_r.omr[vec_pkg::OM_LVS];
  assign setup_pedestal_enable = s_r.ped;
  assign blanking_region_filter_enable = s_r.omr[vec_pkg::OM_BRF];
  assign low_power_sleep_enable = s_r.omr[vec_pkg::OM_SLEEP];
  assign master_slave_select = s_r.tmr[vec_pkg::TM_MS];
  assign timing_mode_field = s_r.tmr[vec_pkg::TM_MODE +: 2];
  assign blank_input_enable = s_r.tmr[vec_pkg::TM_BLANK];
  assign luma_delay_field = s_r.tmr[vec_pkg::TM_LUMA +: 2];
  assign luma_delay_cycles = s_r.luma;
  assign pixel_port_format = s_r.tmr[vec_pkg::TM_PIX];
  assign colour_dac_ypbpr = s_r.ypbpr;
  assign colour_dac_sync = s_r.rgb_sync;
  assign blank_force = s_r.blank;
  assign hsync_out_n = s_r.hs_n;
  assign vsync_out_n = s_r.vs_n;
  assign h_count = s_r.h;
  assign v_count = s_r.v;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_fmt_write: assert property (reg_wr && reg_addr == vec_pkg::OMR_ADDR |=>
    output_format_select == $past(reg_wdata[0])) else $error("format bit not stored");
  a_ypbpr_drive: assert property (s_r.omr[0] && s_r.omr[1] |=> colour_dac_ypbpr)
    else $error("ypbpr not selected");
  a_sync_colour: assert property (s_r.omr[0] && s_r.omr[2] |=> colour_dac_sync)
    else $error("colour sync missing");
  a_vsync_long: assert property (master && !hold && s_r.omr[3] && !pal_select
    && s_r.v == 10'd2 && s_r.h == 11'd0 |=> !vsync_out_n) else $error("long vsync short");
  a_ped_pal: assert property (pal_select |=> !setup_pedestal_enable)
    else $error("pedestal in PAL");
  a_sleep_wake: assert property (reg_wr && reg_addr == vec_pkg::OMR_ADDR
    && !reg_wdata[6] |=> !low_power_sleep_enable) else $error("sleep not left");
  a_sleep_regs: assert property (low_power_sleep_enable && reg_wr
    && reg_addr == vec_pkg::TMR_ADDR |=> s_r.tmr == $past(reg_wdata))
    else $error("write lost in sleep");
  a_slave_idle: assert property (!master |=> hsync_out_n && vsync_out_n)
    else $error("slave drives sync");
  a_blank_gate: assert property (!master && s_r.tmr[3] && !s_r.in_s[2] |=> blank_force)
    else $error("blank ignored");
  a_luma_step: assert property (luma_delay_field == 2'd3 && $stable(luma_delay_field)
    |=> luma_delay_cycles == 8'(3 * vec_pkg::LUMA_STEP_CYC)) else $error("luma delay");
  a_trst_hold: assert property (s_r.tmr[7] |=> h_count == 11'd0 && v_count == 10'd0)
    else $error("counters not held");
  a_trst_restart: assert property ($fell(s_r.tmr[7]) && master && !hold
    |-> h_count == 11'd0 ##1 h_count == 11'd1) else $error("no restart");

  c_omr_write: cover property (reg_wr && reg_addr == vec_pkg::OMR_ADDR);
  c_trst_seq: cover property ($rose(s_r.tmr[7]) ##[1:1000] $fell(s_r.tmr[7]));
  c_sleep_in: cover property ($rose(low_power_sleep_enable));
  c_vs_master: cover property (master && $fell(vsync_out_n));
endmodule

// file: hdl/vec_pkg.sv
// shared constants for the video encoder mode and timing control block
package vec_pkg;
  localparam logic [4:0] OMR_ADDR = 5'h04;
  localparam logic [4:0] TMR_ADDR = 5'h07;
  localparam logic [7:0] OMR_RST = 8'h00;
  localparam logic [7:0] TMR_RST = 8'h00;
  // output mode control fields
  localparam int OM_FMT = 0;
  localparam int OM_COMP = 1;
  localparam int OM_SYNC = 2;
  localparam int OM_LVS = 3;
  localparam int OM_PED = 4;
  localparam int OM_BRF = 5;
  localparam int OM_SLEEP = 6;
  // timing mode control fields
  localparam int TM_MS = 0;
  localparam int TM_MODE = 1;
  localparam int TM_BLANK = 3;
  localparam int TM_LUMA = 4;
  localparam int TM_PIX = 6;
  localparam int TM_RST = 7;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int LUMA_STEP_NS = 74;
  localparam int LUMA_STEP_CYC = (LUMA_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NTSC_LINE_CYC = 1716;
  localparam int PAL_LINE_CYC = 1728;
  localparam int NTSC_LINES = 525;
  localparam int PAL_LINES = 625;
  localparam int HS_WIDTH_CYC = 128;
  localparam int VS_STD_HALF = 2;
  localparam int VS_LONG_NTSC_HALF = 6;
  localparam int VS_LONG_PAL_HALF = 5;
  // arbitrary serial device address, chosen for this block
  localparam logic [6:0] TWI_DEV_ADDR = 7'h2a;
endpackage

// file: hdl/vec_twi_slave.sv
// two-wire serial register port slave with auto-incrementing subaddress
module vec_twi_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary address
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic reg_wr,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_ADDR = 9'h002, S_ACKA = 9'h004, S_SUB = 9'h008, S_ACKS = 9'h010,
    S_WDAT = 9'h020, S_ACKW = 9'h040, S_RDAT = 9'h080, S_RACK = 9'h100
  } vec_twi_st_t;
  typedef struct packed {
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    vec_twi_st_t st;
    logic [7:0] sh;
    logic [3:0] bcnt;
    logic [4:0] sub;
    logic rw, nack, oe, wr;
  } vec_twi_t;
  vec_twi_t s_r, s_nxt;
  logic start, stop, rise, fall;

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_m = scl_in;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_p = s_r.scl_s;
    s_nxt.sda_m = sda_in;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_p = s_r.sda_s;
    s_nxt.wr = 1'b0;
    start = s_r.scl_s & s_r.scl_p & s_r.sda_p & ~s_r.sda_s;
    stop = s_r.scl_s & s_r.scl_p & ~s_r.sda_p & s_r.sda_s;
    rise = s_r.scl_s & ~s_r.scl_p;
    fall = ~s_r.scl_s & s_r.scl_p;
    if (start) begin
      s_nxt.st = S_ADDR;
      s_nxt.bcnt = 4'h0;
      s_nxt.oe = 1'b0;
    end else if (stop) begin
      s_nxt.st = S_IDLE;
      s_nxt.oe = 1'b0;
    end else begin
      case (s_r.st)
        S_IDLE: s_nxt.oe = 1'b0;
        S_ADDR, S_SUB, S_WDAT: begin
          if (rise) begin
            s_nxt.sh = {s_r.sh[6:0], s_r.sda_s};
            s_nxt.bcnt = s_r.bcnt + 4'h1;
          end else if (fall && s_r.bcnt == 4'h8) begin
            s_nxt.oe = 1'b1;
            s_nxt.rw = s_r.sh[0];
            if (s_r.st == S_ADDR) begin
              s_nxt.st = (s_r.sh[7:1] == DEV_ADDR) ? S_ACKA : S_IDLE;
              s_nxt.oe = (s_r.sh[7:1] == DEV_ADDR);
            end else if (s_r.st == S_SUB) begin
              s_nxt.sub = s_r.sh[4:0];
              s_nxt.st = S_ACKS;
            end else begin
              s_nxt.wr = 1'b1;
              s_nxt.st = S_ACKW;
            end
          end
        end
        S_ACKA: if (fall) begin
          s_nxt.bcnt = 4'h0;
          s_nxt.st = s_r.rw ? S_RDAT : S_SUB;
          s_nxt.sh = reg_rdata;
          s_nxt.oe = s_r.rw & ~reg_rdata[7];
        end
        S_ACKS, S_ACKW: if (fall) begin
          s_nxt.oe = 1'b0;
          s_nxt.bcnt = 4'h0;
          s_nxt.st = S_WDAT;
          if (s_r.st == S_ACKW) s_nxt.sub = s_r.sub + 5'h01;
        end
        S_RDAT: begin
          if (rise) begin
            s_nxt.bcnt = s_r.bcnt + 4'h1;
          end else if (fall) begin
            if (s_r.bcnt == 4'h8) begin
              s_nxt.oe = 1'b0;
              s_nxt.st = S_RACK;
            end else begin
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.oe = ~s_r.sh[6];
            end
          end
        end
        S_RACK: begin
          if (rise) begin
            s_nxt.nack = s_r.sda_s;
            s_nxt.sub = s_r.sub + 5'h01;
          end else if (fall) begin
            // master nack ends the read; release and wait for stop
            s_nxt.st = s_r.nack ? S_IDLE : S_RDAT;
            s_nxt.bcnt = 4'h0;
            s_nxt.sh = reg_rdata;
            s_nxt.oe = ~s_r.nack & ~reg_rdata[7];
          end
        end
        default: s_nxt.st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
               sda_p: 1'b1, st: S_IDLE, sh: 8'h00, bcnt: 4'h0, sub: 5'h00,
               rw: 1'b0, nack: 1'b0, oe: 1'b0, wr: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = s_r.oe;
  assign reg_wr = s_r.wr;
  assign reg_addr = s_r.sub;
  assign reg_wdata = s_r.sh;
endmodule

// file: tb/vec_host.sv
// two-wire host model driving the serial register port of the encoder
module vec_host #(
  parameter logic [6:0] DEV = 7'h2a // arbitrary address
) (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_oe_host
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus released, clock high; the bench calls this once so one process drives the pins
  task automatic idle();
    scl = 1'b1;
    sda_oe_host = 1'b0;
  endtask
  // 8 clk phases stay well clear of the 4 clk minimum
  task automatic half();
    repeat (8) @(negedge clk);
  endtask
  task automatic bitx(input logic b, output logic s);
    sda_oe_host = ~b;
    half();
    scl = 1'b1;
    half();
    s = sda_wire;
    scl = 1'b0;
    half();
  endtask
  task automatic start();
    sda_oe_host = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_oe_host = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_oe_host = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_oe_host = 1'b0;
    half();
  endtask
  // mack drives our own ack; nak returns the line level seen in the ack slot
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(~mack, nak);
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] v;
    logic [7:0] q;
    logic n0, n1, n2;
    v = d;
    v[7] = v[7] & (a != vec_pkg::OMR_ADDR);
    v[6] = v[6] & (a != vec_pkg::TMR_ADDR);
    start();
    xfer({DEV, 1'b0}, 1'b0, q, n0);
    xfer({3'h0, a}, 1'b0, q, n1);
    xfer(v, 1'b0, q, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n0, n1, n2, n3;
    start();
    xfer({DEV, 1'b0}, 1'b0, q, n0);
    xfer({3'h0, a}, 1'b0, q, n1);
    start();
    xfer({DEV, 1'b1}, 1'b0, q, n2);
    // single byte read ends in a nack so the device lets go
    xfer(8'hff, 1'b0, d, n3);
    stop();
    nak = n0 | n1 | n2;
  endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the mode and timing control registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NL = 64;
  localparam int PL = 72;
  logic clk, rst_n, scl, host_oe, sda_out, sda_oe, pal, hs_n, vs_n, bl_n;
  logic hso, vso, fmt, comp, soc, lvs, ped, brf, slp, ms, bie, ppf, ydac, sdac, bf;
  logic [1:0] tmf, ldf;
  logic [7:0] ldc;
  logic [10:0] hc;
  logic [9:0] vc;
  int errors, checks, cyc;
  // open drain line with pull-up
  wire logic sda_wire = ~(host_oe | sda_oe);
  vec_host #(.DEV(7'(vec_pkg::TWI_DEV_ADDR))) u_vec_host (
    .clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_oe_host(host_oe));
  vec_mode_timing #(.NTSC_LINE(NL), .PAL_LINE(PL), .NTSC_FRAME(8), .PAL_FRAME(10),
                    .HS_WIDTH(4)) u_vec_mode_timing (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .pal_select(pal), .hsync_in_n(hs_n), .vsync_in_n(vs_n),
    .blank_in_n(bl_n), .hsync_out_n(hso), .vsync_out_n(vso), .output_format_select(fmt),
    .component_standard_select(comp), .sync_on_colour_enable(soc),
    .long_vert_sync_mode(lvs), .setup_pedestal_enable(ped),
    .blanking_region_filter_enable(brf), .low_power_sleep_enable(slp),
    .master_slave_select(ms), .timing_mode_field(tmf), .blank_input_enable(bie),
    .luma_delay_field(ldf), .luma_delay_cycles(ldc), .pixel_port_format(ppf),
    .colour_dac_ypbpr(ydac), .colour_dac_sync(sdac), .blank_force(bf), .h_count(hc),
    .v_count(vc));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic nk;
    u_vec_host.wr_reg(a, d, nk);
    cmp(11'(nk), 11'h0);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic nk;
    u_vec_host.rd_reg(a, q, nk);
    cmp({2'h0, nk, q}, {3'h0, e});
  endtask
  // one whole low pulse, skipping any pulse already under way
  task automatic vs_width(output int n);
    n = 0;
    for (int k = 0; k < 2000 && vso !== 1'b1; k++) tick(1);
    for (int k = 0; k < 2000 && vso !== 1'b0; k++) tick(1);
    for (int k = 0; k < 2000 && vso === 1'b0; k++) begin
      tick(1);
      n++;
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    logic [7:0] om [3];
    logic [7:0] tm [3];
    int n;
    om = '{8'h25, 8'h1a, 8'h17};
    tm = '{8'h0b, 8'h35, 8'h26};
    errors = 0;
    checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    pal = 1'b0;
    hs_n = 1'b1;
    vs_n = 1'b1;
    bl_n = 1'b1;
    u_vec_host.idle();
    tick(8);
    rst_n = 1'b1;
    tick(2);
    wr(5'h07, 8'h80);
    wr(5'h07, 8'h00);
    rdc(5'h04, vec_pkg::OMR_RST);
    rdc(5'h07, vec_pkg::TMR_RST);
    rdc(5'h1f, 8'h00);
    $display("test reset values done");
    foreach (om[i]) begin
      wr(5'h04, om[i]);
      tick(3);
      cmp(11'({fmt, comp, soc, lvs, ped, brf, slp}), 11'({om[i][0], om[i][1], om[i][2],
          om[i][3], om[i][4], om[i][5], om[i][6]}));
      cmp(11'({ydac, sdac}),
          11'({om[i][0] & om[i][1], om[i][0] & om[i][2]}));
      rdc(5'h04, om[i]);
    end
    pal = 1'b1;
    tick(3);
    cmp(11'(ped), 11'h0);
    pal = 1'b0;
    $display("test output mode done");
    bl_n = 1'b0;
    foreach (tm[i]) begin
      wr(5'h07, tm[i]);
      tick(6);
      cmp(11'({ldf, bie, tmf, ms}), 11'(tm[i][5:0]));
      cmp(11'(ppf), 11'h0);
      cmp(11'(ldc), 11'(int'(tm[i][5:4]) * vec_pkg::LUMA_STEP_CYC));
      cmp(11'(bf), 11'(tm[i][3] & ~tm[i][0]));
      rdc(5'h07, tm[i]);
    end
    wr(5'h07, 8'h08);
    tick(6);
    cmp(11'(bf), 11'h1);
    bl_n = 1'b1;
    wr(5'h07, 8'h00);
    // slave source holds vsync low three lines
    hs_n = 1'b0;
    vs_n = 1'b0;
    // two synchroniser stages plus the counter register; later a line end could move v
    tick(3);
    cmp(11'(vc), 11'h0);
    cmp(hc, 11'h0);
    cmp(11'({hso, vso}), 11'h3);
    hs_n = 1'b1;
    tick(3 * NL);
    vs_n = 1'b1;
    $display("test timing control done");
    wr(5'h04, 8'h40);
    tick(3);
    cmp(11'(slp), 11'h1);
    rdc(5'h04, 8'h40);
    wr(5'h07, 8'h0a);
    rdc(5'h07, 8'h0a);
    wr(5'h04, 8'h00);
    tick(3);
    cmp(11'(slp), 11'h0);
    wr(5'h04, 8'h40);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(2);
    cmp(11'(slp), 11'h0);
    $display("test sleep done");
    wr(5'h07, 8'h81);
    for (int k = 0; k < 3; k++) begin
      tick(40);
      cmp(hc, 11'h0);
      cmp(11'(vc), 11'h0);
    end
    wr(5'h07, 8'h01);
    cmp(11'(vc == 0 && hc != 0 && hc < 11'(NL)), 11'h1);
    // master line sync low for the first four counts, one cycle behind
    for (int k = 0; k < 200 && hc !== 11'd2; k++) tick(1);
    cmp(11'(hso), 11'h0);
    for (int k = 0; k < 200 && hc !== 11'd10; k++) tick(1);
    cmp(11'(hso), 11'h1);
    $display("test counter reset done");
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < 2; l++) begin
        pal = p[0];
        wr(5'h04, {4'h0, l[0], 3'h0});
        vs_width(n);
        cmp(11'(n), 11'(l ? (p ? PL * 5 / 2 : NL * 3) : (p ? PL : NL)));
      end
    end
    $display("test vertical sync done");
    give_verdict();
  end
endmodule
